// *** hdl/mpu_pkg.sv ***
// Shared constants and types of the protection-unit attribute resolver
package mpu_pkg;

  // ----------------------------------------------------------------
  // Access levels and programming commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LVL_USER, LVL_KERNEL, LVL_HYP} level_e;
  typedef enum logic [2:0] {
    PG_SELECT, PG_BASE, PG_LIMIT, PG_DIRECT_BASE, PG_DIRECT_LIMIT,
    PG_ENABLES
  } prog_e;

  // ----------------------------------------------------------------
  // Memory type codes, ordered strictest first so merge is a minimum
  // ----------------------------------------------------------------
  localparam logic [2:0] MT_DEV_STRICTEST = 3'h0;
  localparam logic [2:0] MT_DEV_EARLY_ACK = 3'h1;
  localparam logic [2:0] MT_NORMAL_NC = 3'h2;
  localparam logic [2:0] MT_NORMAL_WT = 3'h3;
  localparam logic [2:0] MT_NORMAL_WB = 3'h4;

  // Shareability codes, ordered so merge is a maximum
  localparam logic [1:0] SH_NON = 2'h0;
  localparam logic [1:0] SH_INNER = 2'h1;
  localparam logic [1:0] SH_OUTER = 2'h2;

  // Access permission codes
  localparam logic [1:0] AP_PRIV_RW = 2'h0;
  localparam logic [1:0] AP_ANY_RW = 2'h1;

  // ----------------------------------------------------------------
  // Region word layouts
  // ----------------------------------------------------------------
  localparam int ADDR_LSB = 6;
  localparam int SH_LSB = 3;
  localparam int AP_LSB = 1;
  localparam int XN_BIT = 0;
  localparam int ATTR_LSB = 1;
  localparam int EN_BIT = 0;
  localparam int DIRECT_REGIONS = 32;
  localparam logic [31:0] LIMIT_FILL = 32'h0000003F;

  // ----------------------------------------------------------------
  // Default map boundaries (top bits of the address)
  // ----------------------------------------------------------------
  localparam logic [31:0] MAP_WT_BASE = 32'h40000000;
  localparam logic [31:0] MAP_NC_BASE = 32'h60000000;
  localparam logic [31:0] MAP_DEV_BASE = 32'h80000000;
  localparam logic [31:0] MAP_STRICT_BASE = 32'hC0000000;

  // Fault reporting
  localparam logic [1:0] FAULT_LEVEL = 2'h0;

  // Resolved attributes of one stage
  typedef struct packed {
    logic [2:0] mtype;
    logic [1:0] share;
    logic xn;
    logic [1:0] ap;
    logic miss;
  } attr_s;

endpackage : mpu_pkg

// *** hdl/mpu_region_table.sv ***
// Region store of one protection unit with a registered lookup port
`timescale 1ns/1ps
module mpu_region_table #(
  parameter int NUM_REGIONS = 32,
  parameter int IW = $clog2(NUM_REGIONS)
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Write port
  input wire logic i_wr_base,
  input wire logic i_wr_limit,
  input wire logic i_wr_enables,
  input wire logic [IW-1:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // Lookup port, answer one cycle later
  input wire logic [31:0] i_lookup_addr,
  output logic o_hit,
  output logic [31:0] o_base,
  output logic [31:0] o_limit,
  // Enable bits of the first regions
  output logic [31:0] o_enables
);

  logic [31:0] base_q [NUM_REGIONS];
  logic [31:0] limit_q [NUM_REGIONS];
  logic hit_d;
  logic [IW-1:0] idx_d;

  // ----------------------------------------------------------------
  // Storage; only the enable bit needs a reset value
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      if (i_rst)
        limit_q[i][mpu_pkg::EN_BIT] <= 1'b0;
      else if (i_wr_enables && i < mpu_pkg::DIRECT_REGIONS)
        limit_q[i][mpu_pkg::EN_BIT] <= i_wr_data[i];
      else if (i_wr_limit && i_wr_idx == IW'(i))
        limit_q[i] <= i_wr_data;
      if (i_wr_base && i_wr_idx == IW'(i))
        base_q[i] <= i_wr_data;
    end
  end

  // Lowest-numbered enabled region that covers the address
  always_comb
  begin
    hit_d = 1'b0;
    idx_d = '0;
    for (int i = NUM_REGIONS - 1; i >= 0; i--)
    begin
      if (limit_q[i][mpu_pkg::EN_BIT] &&
          i_lookup_addr[31:mpu_pkg::ADDR_LSB] >=
            base_q[i][31:mpu_pkg::ADDR_LSB] &&
          i_lookup_addr[31:mpu_pkg::ADDR_LSB] <=
            limit_q[i][31:mpu_pkg::ADDR_LSB])
      begin
        hit_d = 1'b1;
        idx_d = IW'(i);
      end
    end
  end

  // Registered read data
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_hit <= 1'b0;
      o_base <= 32'h00000000;
      o_limit <= 32'h00000000;
    end
    else
    begin
      o_hit <= hit_d;
      o_base <= base_q[idx_d];
      o_limit <= limit_q[idx_d];
    end
  end

  always_comb
  begin
    o_enables = 32'h00000000;
    for (int i = 0; i < NUM_REGIONS && i < 32; i++)
      o_enables[i] = limit_q[i][mpu_pkg::EN_BIT];
  end

endmodule : mpu_region_table

// *** hdl/mpu_default_map_check.sv ***
// Two-level protection unit: default maps, background checks, merge
//
// Summary of operation
// - A disabled unit applies its own fixed default map to every access.
// - Enabled unit with background on: privileged misses use background.
// - Kernel background checking only while kernel background enable is 1.
// - Hypervisor background applies to hypervisor accesses when enabled.
// - Default-cacheable off: kernel background uses kernel default map.
// - Fetch below 0x80000000 executable, cacheability by icache; above XN.
// - Data normal ranges: WB, WT, NC with dcache on; all NC when off.
// - 0x80000000 up device early-ack; 0xC0000000 up strictest device.
// - Hypervisor maps equal kernel maps, chosen by hypervisor cache bits.
// - Default-cacheable on: kernel background is normal WB non-shareable exec.
// - Hypervisor background always uses the hypervisor default map.
// - Each unit is enabled exactly when its enable bit is 1.
// - Regions programmed indirectly via select, or directly for first 32.
// - Hypervisor unit has a direct enable word for regions 0 to 31.
// - Faults report level 0; queries give 64-bit result, full address.
// - Debug route set: stage 2 faults in debug become debug events.
// - Both on: hyp uses hyp unit; others kernel unit then hyp stage 2.
// - Only hyp on: others take kernel background then hyp stage 2.
// - Only kernel on: hyp uses hyp background; stage 2 from it too.
// - Both off: background regions for both stages.
// - Write-back anywhere in a line lets the whole line be write-back.
// - A stage 1 denial is a stage 1 fault whatever stage 2 says.
// - Any combined device type is treated as outer shareable.
`timescale 1ns/1ps
module mpu_default_map_check #(
  parameter int NUM_REGIONS = 32,
  parameter int IW = $clog2(NUM_REGIONS)
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Access request from the pipeline
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic [1:0] i_acc_level,
  input wire logic i_acc_fetch,
  input wire logic i_acc_write,
  input wire logic i_acc_query,
  input wire logic i_debug_state,
  // Control bits
  input wire logic i_kernel_unit_enable,
  input wire logic i_kernel_background_enable,
  input wire logic i_kernel_icache_enable,
  input wire logic i_kernel_dcache_enable,
  input wire logic i_hyp_unit_enable,
  input wire logic i_hyp_background_enable,
  input wire logic i_hyp_icache_enable,
  input wire logic i_hyp_dcache_enable,
  input wire logic i_default_cacheable_ctrl,
  input wire logic i_stage2_enable,
  input wire logic i_debug_stage2_fault_route,
  // Region programming
  input wire logic i_prog_valid,
  input wire logic i_prog_hyp,
  input wire logic [2:0] i_prog_kind,
  input wire logic [4:0] i_prog_index,
  input wire logic [31:0] i_prog_data,
  // Access answer
  output logic o_rsp_valid,
  output logic [2:0] o_rsp_mem_type,
  output logic [1:0] o_rsp_share,
  output logic o_rsp_xn,
  output logic o_rsp_fault,
  output logic o_rsp_fault_stage2,
  output logic [1:0] o_rsp_fault_level,
  output logic o_rsp_debug_event,
  output logic o_rsp_line_wb,
  output logic [63:0] o_translation_result_reg,
  // Programming state
  output logic [IW-1:0] o_kernel_region_select,
  output logic [IW-1:0] o_hyp_region_select,
  output logic [31:0] o_hyp_region_enables
);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Fixed default map of a unit; also its background region
  function automatic mpu_pkg::attr_s dflt_map(
    input logic [31:0] addr,
    input logic fetch,
    input logic icache,
    input logic dcache,
    input logic dc
  );
    mpu_pkg::attr_s a;
    a = '{mtype: mpu_pkg::MT_NORMAL_NC, share: mpu_pkg::SH_OUTER,
          xn: 1'b0, ap: mpu_pkg::AP_ANY_RW, miss: 1'b0};
    if (dc)
    begin
      a.mtype = mpu_pkg::MT_NORMAL_WB;
      a.share = mpu_pkg::SH_NON;
    end
    else if (fetch)
    begin
      a.xn = (addr >= mpu_pkg::MAP_DEV_BASE);
      if (icache)
      begin
        a.mtype = mpu_pkg::MT_NORMAL_WT;
        a.share = mpu_pkg::SH_NON;
      end
    end
    else if (addr >= mpu_pkg::MAP_STRICT_BASE)
      a.mtype = mpu_pkg::MT_DEV_STRICTEST;
    else if (addr >= mpu_pkg::MAP_DEV_BASE)
      a.mtype = mpu_pkg::MT_DEV_EARLY_ACK;
    else if (dcache && addr < mpu_pkg::MAP_WT_BASE)
    begin
      a.mtype = mpu_pkg::MT_NORMAL_WB;
      a.share = mpu_pkg::SH_NON;
    end
    else if (dcache && addr < mpu_pkg::MAP_NC_BASE)
    begin
      a.mtype = mpu_pkg::MT_NORMAL_WT;
      a.share = mpu_pkg::SH_NON;
    end
    return a;
  endfunction : dflt_map

  // Attributes held in a matched region word pair
  function automatic mpu_pkg::attr_s region_attr(
    input logic [31:0] base,
    input logic [31:0] limit
  );
    mpu_pkg::attr_s a;
    a.mtype = limit[mpu_pkg::ATTR_LSB +: 3];
    a.share = base[mpu_pkg::SH_LSB +: 2];
    a.xn = base[mpu_pkg::XN_BIT];
    a.ap = base[mpu_pkg::AP_LSB +: 2];
    a.miss = 1'b0;
    return a;
  endfunction : region_attr

  // One unit: disabled, hit, background, or denied
  function automatic mpu_pkg::attr_s unit_resolve(
    input logic en,
    input logic bg,
    input logic hit,
    input mpu_pkg::attr_s region,
    input mpu_pkg::attr_s dflt
  );
    mpu_pkg::attr_s a;
    a = dflt;
    if (en)
    begin
      if (hit)
        a = region;
      else if (!bg)
        a.miss = 1'b1;
    end
    return a;
  endfunction : unit_resolve

  // Permission and execute check of one stage
  function automatic logic denied(
    input mpu_pkg::attr_s a,
    input logic user,
    input logic write,
    input logic fetch
  );
    return a.miss || (user && !a.ap[0]) || (write && a.ap[1]) ||
           (fetch && a.xn);
  endfunction : denied

  // ----------------------------------------------------------------
  // Region programming
  // ----------------------------------------------------------------
  logic k_wr_base, k_wr_limit, h_wr_base, h_wr_limit, h_wr_enables;
  logic [IW-1:0] k_wr_idx, h_wr_idx;
  logic direct_w;

  // Direct commands name the region; indirect ones use the select
  always_comb
  begin
    direct_w = i_prog_kind == 3'(mpu_pkg::PG_DIRECT_BASE) ||
               i_prog_kind == 3'(mpu_pkg::PG_DIRECT_LIMIT);
    k_wr_idx = direct_w ? IW'(i_prog_index) : o_kernel_region_select;
    h_wr_idx = direct_w ? IW'(i_prog_index) : o_hyp_region_select;
    k_wr_base = i_prog_valid && !i_prog_hyp &&
      (i_prog_kind == 3'(mpu_pkg::PG_BASE) ||
       i_prog_kind == 3'(mpu_pkg::PG_DIRECT_BASE));
    k_wr_limit = i_prog_valid && !i_prog_hyp &&
      (i_prog_kind == 3'(mpu_pkg::PG_LIMIT) ||
       i_prog_kind == 3'(mpu_pkg::PG_DIRECT_LIMIT));
    h_wr_base = i_prog_valid && i_prog_hyp &&
      (i_prog_kind == 3'(mpu_pkg::PG_BASE) ||
       i_prog_kind == 3'(mpu_pkg::PG_DIRECT_BASE));
    h_wr_limit = i_prog_valid && i_prog_hyp &&
      (i_prog_kind == 3'(mpu_pkg::PG_LIMIT) ||
       i_prog_kind == 3'(mpu_pkg::PG_DIRECT_LIMIT));
    h_wr_enables = i_prog_valid && i_prog_hyp &&
      i_prog_kind == 3'(mpu_pkg::PG_ENABLES);
  end

  // Region select registers of both units
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_kernel_region_select <= '0;
      o_hyp_region_select <= '0;
    end
    else if (i_prog_valid && i_prog_kind == 3'(mpu_pkg::PG_SELECT))
    begin
      if (i_prog_hyp)
        o_hyp_region_select <= IW'(i_prog_data);
      else
        o_kernel_region_select <= IW'(i_prog_data);
    end
  end

  // ----------------------------------------------------------------
  // Region tables, looked up in the request cycle
  // ----------------------------------------------------------------
  logic k_hit, h_hit;
  logic [31:0] k_base, k_limit, h_base, h_limit;

  mpu_region_table #(.NUM_REGIONS(NUM_REGIONS), .IW(IW)) u_kernel_tab (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr_base(k_wr_base),
    .i_wr_limit(k_wr_limit),
    .i_wr_enables(1'b0),
    .i_wr_idx(k_wr_idx),
    .i_wr_data(i_prog_data),
    .i_lookup_addr(i_acc_addr),
    .o_hit(k_hit),
    .o_base(k_base),
    .o_limit(k_limit),
    .o_enables()
  );

  mpu_region_table #(.NUM_REGIONS(NUM_REGIONS), .IW(IW)) u_hyp_tab (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr_base(h_wr_base),
    .i_wr_limit(h_wr_limit),
    .i_wr_enables(h_wr_enables),
    .i_wr_idx(h_wr_idx),
    .i_wr_data(i_prog_data),
    .i_lookup_addr(i_acc_addr),
    .o_hit(h_hit),
    .o_base(h_base),
    .o_limit(h_limit),
    .o_enables(o_hyp_region_enables)
  );

  // Request fields follow the table lookup by one cycle
  logic req_valid_q, req_fetch_q, req_write_q, req_query_q, req_debug_q;
  logic [31:0] req_addr_q;
  logic [1:0] req_level_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      req_valid_q <= 1'b0;
    else
      req_valid_q <= i_acc_valid;
    req_addr_q <= i_acc_addr;
    req_level_q <= i_acc_level;
    req_fetch_q <= i_acc_fetch;
    req_write_q <= i_acc_write;
    req_query_q <= i_acc_query;
    req_debug_q <= i_debug_state;
  end

  // ----------------------------------------------------------------
  // Stage resolution and merge
  // ----------------------------------------------------------------
  mpu_pkg::attr_s k_dflt, h_dflt, s1, s2, fin;
  logic is_hyp, is_user, priv, s1_fault, s2_fault, s2_on;

  always_comb
  begin
    is_hyp = req_level_q == 2'(mpu_pkg::LVL_HYP);
    is_user = req_level_q == 2'(mpu_pkg::LVL_USER);
    priv = !is_user;
    // Kernel background: cacheable override or kernel map
    k_dflt = dflt_map(req_addr_q, req_fetch_q, i_kernel_icache_enable,
                      i_kernel_dcache_enable,
                      i_default_cacheable_ctrl);
    // Hypervisor background: own cache bits, never the override
    h_dflt = dflt_map(req_addr_q, req_fetch_q, i_hyp_icache_enable,
                      i_hyp_dcache_enable, 1'b0);
    // Stage 2 only for kernel and user accesses
    s2_on = !is_hyp && i_stage2_enable;
    if (is_hyp)
      s1 = unit_resolve(i_hyp_unit_enable, i_hyp_background_enable,
                        h_hit, region_attr(h_base, h_limit),
                        h_dflt);
    else
      s1 = unit_resolve(i_kernel_unit_enable,
                        i_kernel_background_enable && priv, k_hit,
                        region_attr(k_base, k_limit),
                        k_dflt);
    // Hyp unit as stage 2 has no background for lower levels
    s2 = unit_resolve(i_hyp_unit_enable, 1'b0, h_hit,
                      region_attr(h_base, h_limit),
                      h_dflt);
    s1_fault = denied(s1, is_user, req_write_q, req_fetch_q);
    s2_fault = s2_on && denied(s2, is_user, req_write_q, req_fetch_q);
    fin = s1;
    if (s2_on)
    begin
      // Strictest type wins; same ordering covers cacheability
      fin.mtype = (s2.mtype < s1.mtype) ? s2.mtype : s1.mtype;
      fin.share = (s2.share > s1.share) ? s2.share : s1.share;
      fin.xn = s1.xn || s2.xn;
    end
    if (fin.mtype <= mpu_pkg::MT_NORMAL_NC)
      fin.share = mpu_pkg::SH_OUTER;
  end

  // ----------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_mem_type <= mpu_pkg::MT_DEV_STRICTEST;
      o_rsp_share <= mpu_pkg::SH_OUTER;
      o_rsp_xn <= 1'b0;
      o_rsp_fault <= 1'b0;
      o_rsp_fault_stage2 <= 1'b0;
      o_rsp_debug_event <= 1'b0;
      o_rsp_line_wb <= 1'b0;
    end
    else
    begin
      o_rsp_valid <= req_valid_q;
      o_rsp_mem_type <= fin.mtype;
      o_rsp_share <= fin.share;
      o_rsp_xn <= fin.xn;
      // Stage 1 denial outranks any stage 2 verdict
      o_rsp_fault <= req_valid_q && (s1_fault || (s2_fault &&
        !(req_debug_q && i_debug_stage2_fault_route)));
      o_rsp_fault_stage2 <= req_valid_q && !s1_fault && s2_fault;
      o_rsp_debug_event <= req_valid_q && !s1_fault && s2_fault &&
        req_debug_q && i_debug_stage2_fault_route;
      // Region granule equals the line, so a line never mixes types
      o_rsp_line_wb <= fin.mtype == mpu_pkg::MT_NORMAL_WB;
    end
  end

  assign o_rsp_fault_level = mpu_pkg::FAULT_LEVEL;

  // Query result, 64-bit layout, whole address used for the lookup
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_translation_result_reg <= 64'h0000000000000000;
    else if (req_valid_q && req_query_q)
    begin
      if (s1_fault || s2_fault)
        o_translation_result_reg <= {56'h0, mpu_pkg::FAULT_LEVEL,
          !s1_fault, 4'h0, 1'b1};
      else
        o_translation_result_reg <= {5'h00, fin.mtype, 24'h000000,
          req_addr_q[31:12], 1'b0, fin.share, 9'h000};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rsp_two_cycles: assert property (i_acc_valid |-> ##2 o_rsp_valid)
    else $error("answer not two cycles after request");
  a_level_zero: assert property (
    o_rsp_fault |-> o_rsp_fault_level == 2'h0)
    else $error("fault level not zero");
  a_device_outer_share: assert property (
    o_rsp_valid && o_rsp_mem_type <= mpu_pkg::MT_DEV_EARLY_ACK
    |-> o_rsp_share == mpu_pkg::SH_OUTER)
    else $error("device memory not outer shareable");
  a_high_fetch_xn: assert property (
    req_valid_q && req_fetch_q && req_addr_q[31] && !is_hyp &&
    !i_kernel_unit_enable && !i_default_cacheable_ctrl
    |=> o_rsp_fault && o_rsp_xn)
    else $error("fetch above 0x7FFFFFFF not refused");
  a_dc_override: assert property (
    req_valid_q && !is_hyp && !i_kernel_unit_enable && !s2_on &&
    i_default_cacheable_ctrl
    |=> !o_rsp_fault && o_rsp_mem_type == mpu_pkg::MT_NORMAL_WB &&
        o_rsp_share == mpu_pkg::SH_NON && !o_rsp_xn)
    else $error("cacheable override attributes wrong");
  a_strict_device_map: assert property (
    req_valid_q && !req_fetch_q && is_hyp && !i_hyp_unit_enable &&
    req_addr_q[31:30] == 2'h3
    |=> o_rsp_mem_type == mpu_pkg::MT_DEV_STRICTEST)
    else $error("top quarter not strictest device");
  a_low_data_wb: assert property (
    req_valid_q && !req_fetch_q && is_hyp && !i_hyp_unit_enable &&
    i_hyp_dcache_enable && req_addr_q[31:30] == 2'h0
    |=> o_rsp_mem_type == mpu_pkg::MT_NORMAL_WB && o_rsp_line_wb)
    else $error("low data range not write-back");
  a_user_miss_denied: assert property (
    req_valid_q && is_user && i_kernel_unit_enable && !k_hit
    |=> o_rsp_fault && !o_rsp_fault_stage2)
    else $error("user miss not faulted");
  a_stage1_first: assert property (
    req_valid_q && s1_fault && s2_fault
    |=> o_rsp_fault && !o_rsp_fault_stage2 && !o_rsp_debug_event)
    else $error("stage 2 fault reported over stage 1");
  a_debug_route: assert property (
    o_rsp_debug_event |-> !o_rsp_fault && $past(req_debug_q) &&
    $past(i_debug_stage2_fault_route))
    else $error("debug event without routing");

  c_stage2_fault: cover property (o_rsp_valid && o_rsp_fault_stage2);
  c_debug_event: cover property (o_rsp_debug_event);
  c_background_hit: cover property (
    req_valid_q && priv && i_kernel_unit_enable && !k_hit && !s1_fault);
  c_query_done: cover property (req_valid_q && req_query_q ##1 1'b1);

endmodule : mpu_default_map_check

// *** test/cpu_pipe_model.sv ***
// Pipeline model that issues accesses to the protection unit
`timescale 1ns/1ps
module cpu_pipe_model (
  // Clock
  input wire logic i_ref_clk,
  // Access request
  output logic o_valid,
  output logic [31:0] o_addr,
  output logic [1:0] o_level,
  output logic o_fetch,
  output logic o_write,
  output logic o_query
);
  // Idle bus from time zero
  initial
  begin
    {o_valid, o_addr, o_level, o_fetch, o_write, o_query} = '0;
  end

  // One request held over its taking edge; the address is then scrambled
  // so a stale value is never mistaken for a live one
  task automatic issue(input logic [31:0] a, input logic [1:0] l,
    input logic [2:0] fwq);
    {o_valid, o_addr, o_level} = {1'b1, a, l};
    {o_fetch, o_write, o_query} = fwq;
    @(posedge i_ref_clk);
    #1;
    o_valid = 1'b0;
    o_addr = ~a;
  endtask : issue
endmodule : cpu_pipe_model

// *** test/tb.sv ***
// Self-checking bench of the two-level protection unit resolver
`timescale 1ns/1ps
module tb;
  // ------------
  // Signals
  // ------------
  typedef struct packed {
    logic [1:0] l;
    logic [2:0] fcd;
    logic [31:0] a;
    logic [2:0] mt;
    logic [1:0] sh;
  } row_s;
  logic clk, rst, rv, xn, ft, f2, de, lw, av, af, aw, aq, pv, ph;
  logic [1:0] sh, fl, al;
  logic [2:0] mt, pk;
  logic [4:0] ks, hs, pi;
  logic [11:0] ctl;
  logic [31:0] he, aa, pd;
  logic [63:0] par;
  int n_mismatch = 0;
  int checks_done = 0;
  row_s r;
  // Level, fetch/cache/dc, address, type, share
  row_s rows [15] = '{
    {2'h1, 3'h4, 32'h00000000, 3'h2, 2'h2},
    {2'h1, 3'h6, 32'h7FFFFFFF, 3'h3, 2'h0},
    {2'h1, 3'h2, 32'h3FFFFFFF, 3'h4, 2'h0},
    {2'h1, 3'h2, 32'h40000000, 3'h3, 2'h0},
    {2'h1, 3'h2, 32'h5FFFFFFF, 3'h3, 2'h0},
    {2'h1, 3'h2, 32'h60000000, 3'h2, 2'h2},
    {2'h1, 3'h2, 32'h80000000, 3'h1, 2'h2},
    {2'h1, 3'h0, 32'hBFFFFFFF, 3'h1, 2'h2},
    {2'h1, 3'h2, 32'hC0000000, 3'h0, 2'h2},
    {2'h1, 3'h0, 32'h00000000, 3'h2, 2'h2},
    {2'h2, 3'h2, 32'h00000000, 3'h4, 2'h0},
    {2'h2, 3'h6, 32'h10000000, 3'h3, 2'h0},
    {2'h1, 3'h1, 32'hC0000000, 3'h4, 2'h0},
    {2'h2, 3'h3, 32'hC0000000, 3'h0, 2'h2},
    {2'h0, 3'h5, 32'h90000000, 3'h4, 2'h0}
  };

  mpu_default_map_check dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_acc_valid(av), .i_acc_addr(aa),
    .i_acc_level(al), .i_acc_fetch(af), .i_acc_write(aw),
    .i_acc_query(aq), .i_debug_state(ctl[11]),
    .i_kernel_unit_enable(ctl[0]), .i_kernel_background_enable(ctl[1]),
    .i_kernel_icache_enable(ctl[2]), .i_kernel_dcache_enable(ctl[3]),
    .i_hyp_unit_enable(ctl[4]), .i_hyp_background_enable(ctl[5]),
    .i_hyp_icache_enable(ctl[6]), .i_hyp_dcache_enable(ctl[7]),
    .i_default_cacheable_ctrl(ctl[8]), .i_stage2_enable(ctl[9]),
    .i_debug_stage2_fault_route(ctl[10]), .i_prog_valid(pv),
    .i_prog_hyp(ph), .i_prog_kind(pk), .i_prog_index(pi), .i_prog_data(pd),
    .o_rsp_valid(rv), .o_rsp_mem_type(mt), .o_rsp_share(sh), .o_rsp_xn(xn),
    .o_rsp_fault(ft), .o_rsp_fault_stage2(f2), .o_rsp_fault_level(fl),
    .o_rsp_debug_event(de), .o_rsp_line_wb(lw),
    .o_translation_result_reg(par), .o_kernel_region_select(ks),
    .o_hyp_region_select(hs), .o_hyp_region_enables(he)
  );
  cpu_pipe_model cpu_u (
    .i_ref_clk(clk), .o_valid(av), .o_addr(aa), .o_level(al),
    .o_fetch(af), .o_write(aw), .o_query(aq)
  );

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [63:0] seen,
    input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Access, then a bounded wait for the answer two edges later
  task automatic acc(input logic [31:0] a, input logic [1:0] l,
    input logic [2:0] fwq);
    int k;
    cpu_u.issue(a, l, fwq);
    for (k = 0; k < 4 && rv !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (rv !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask : acc

  task automatic prog(input logic h, input logic [2:0] kd,
    input logic [4:0] ix, input logic [31:0] d);
    {pv, ph, pk, pi, pd} = {1'b1, h, kd, ix, d};
    @(posedge clk);
    #1;
    pv = 1'b0;
    pd = ~d;
    // Idle edge, so two commands never touch the strobe in one step
    @(posedge clk);
    #1;
  endtask : prog

  // Reset, table of default-map cases, then hand-written cases
  initial
  begin
    {rst, ctl, pv, ph, pk, pi, pd} = {1'b1, 12'h000, 42'h0};
    repeat (5) @(posedge clk);
    #1;
    chk("reset share", sh, 2'h2);
    chk("reset enables", he, 32'h0);
    rst = 1'b0;
    foreach (rows[i])
    begin
      r = rows[i];
      ctl = {3'h0, r.fcd[0], {2{(r.l == 2'h2) ~^ r.fcd[1]}}, 2'h0,
        {2{(r.l == 2'h2) ^ r.fcd[1]}}, 2'h0};
      acc(r.a, r.l, {r.fcd[2], 2'b00});
      chk("mem type", mt, r.mt);
      chk("share", sh, r.sh);
      chk("line wb", lw, r.mt == 3'h4);
      if (r.fcd[2])
        chk("exec", xn, 1'b0);
    end
    ctl = 12'h000;
    acc(32'h80000000, 2'h1, 3'h4);
    chk("exec never", xn, 1'b1);
    acc(32'h12345678, 2'h1, 3'h1);
    chk("query ok", {par[58:56], par[31:12], par[10:9], par[0]},
      {3'h2, 20'h12345, 2'h2, 1'b0});
    ctl = 12'h001;
    acc(32'h00001000, 2'h1, 3'h1);
    chk("no region", ft, 1'b1);
    chk("query fault", {fl, par[7:6], par[5], par[0]}, 6'h01);
    ctl = 12'h003;
    acc(32'h00001000, 2'h1, 3'h0);
    chk("bg kernel", ft, 1'b0);
    acc(32'h00001000, 2'h0, 3'h0);
    chk("bg user", ft, 1'b1);
    ctl = 12'h010;
    acc(32'h00001000, 2'h2, 3'h0);
    chk("hyp no bg", ft, 1'b1);
    ctl = 12'h030;
    acc(32'h00001000, 2'h2, 3'h0);
    chk("hyp bg", ft, 1'b0);
    // Direct region 0: 0x1000 any RW write-back; indirect 2: RO device
    prog(1'b0, 3'h3, 5'h00, 32'h00001002);
    prog(1'b0, 3'h4, 5'h00, 32'h00001FC9);
    prog(1'b0, 3'h0, 5'h00, 32'h00000002);
    chk("kernel select", ks, 5'h02);
    prog(1'b0, 3'h1, 5'h00, 32'h00004006);
    prog(1'b0, 3'h2, 5'h00, 32'h00004FC3);
    ctl = 12'h001;
    acc(32'h00001040, 2'h0, 3'h0);
    chk("direct hit", {ft, mt, sh}, 6'h10);
    acc(32'h00002000, 2'h0, 3'h0);
    chk("outside", ft, 1'b1);
    acc(32'h00004100, 2'h0, 3'h0);
    chk("indirect hit", {ft, mt, sh}, 6'h06);
    acc(32'h00004100, 2'h0, 3'h2);
    chk("read only", ft, 1'b1);
    ctl = 12'h211;
    acc(32'h00004100, 2'h0, 3'h2);
    chk("s1 wins", {ft, f2}, 2'h2);
    acc(32'h00004100, 2'h0, 3'h0);
    chk("s2 miss", {ft, f2}, 2'h3);
    ctl = 12'hE11;
    acc(32'h00004100, 2'h0, 3'h0);
    chk("debug event", de, 1'b1);
    ctl = 12'h201;
    acc(32'h00001040, 2'h0, 3'h0);
    chk("kernel only", {ft, mt, sh}, 6'h0A);
    ctl = 12'h210;
    acc(32'h00001040, 2'h0, 3'h0);
    chk("hyp only", {ft, f2}, 2'h3);
    ctl = 12'h208;
    acc(32'h00001040, 2'h0, 3'h0);
    chk("both off", {ft, mt, sh}, 6'h0A);
    prog(1'b1, 3'h0, 5'h00, 32'h00000007);
    chk("hyp select", hs, 5'h07);
    prog(1'b1, 3'h5, 5'h00, 32'hA5A5A5A5);
    chk("hyp enables", he, 32'hA5A5A5A5);
    // Mid-run reset clears selects, enables, answer and query result
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset regs", {rv, ks, hs, he}, 43'h0);
    chk("reset query", par, 64'h0);
    finish_test();
  end
endmodule : tb
